// File: include/iop_pkg.sv
// Purpose: Shared constants for the I/O port pin control block.
// Assumes: AHB-Lite register bus with 32-bit data, one word per register.
// Notes: Offsets are byte addresses inside the block's window.
package iop_pkg;
   // ==========================================================
   // Register offsets.
   localparam logic [7:0] IOP_OFF_DATA = 8'h00;
   localparam logic [7:0] IOP_OFF_DIR = 8'h04;
   localparam logic [7:0] IOP_OFF_OPT = 8'h08;
   localparam logic [7:0] IOP_OFF_IRQ_STAT = 8'h0C;
   localparam logic [7:0] IOP_OFF_IRQ_MASK = 8'h10;
   localparam logic [7:0] IOP_OFF_CFG = 8'h14;
   localparam logic [7:0] IOP_OFF_PEND = 8'h18;
   // ==========================================================
   // Reset values, field positions and bus transfer codes.
   localparam logic [7:0] IOP_RST_BYTE = 8'h00;
   localparam int IOP_CFG_GMASK_BIT = 0;
   localparam int IOP_CFG_TRUE_OD_LSB = 8;
   localparam logic [1:0] IOP_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] IOP_HTRANS_SEQ = 2'h3;
   // ==========================================================
   // Pin modes selected by the direction and option pair.
   typedef enum logic [1:0] {
      IOP_MODE_FLOAT_IN = 2'b00,
      IOP_MODE_PULLUP_IRQ = 2'b01,
      IOP_MODE_OPEN_DRAIN = 2'b10,
      IOP_MODE_PUSH_PULL = 2'b11
   } iop_mode_t;
endpackage

// File: include/iop_sync_if.sv
`timescale 1ns/1ps
// Purpose: Carries raw pad levels into the synchroniser and sampled levels back.
// Assumes: One clock domain.
// Notes: Width follows the port width parameter.
interface iop_sync_if #(parameter int W = 8);
   logic [W-1:0] raw;
   logic [W-1:0] sync;
   modport core (output raw, input sync);
   modport sync_side (input raw, output sync);
endinterface

// File: src/iop_sync.sv
`timescale 1ns/1ps
// Purpose: Two-flop synchroniser for the pad input levels.
// Assumes: Pads are asynchronous to hclk.
// Notes: The first stage feeds only the second stage.
module iop_sync #(
   parameter int W = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   iop_sync_if.sync_side s
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   // ==========================================================
   // Two stages; metastability settles in the first.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= s.raw;
         sync_q <= meta_q;
      end
   end
   assign s.sync = sync_q;
endmodule

// File: src/iop_port.sv
`timescale 1ns/1ps
// Purpose: One 8-bit general-purpose I/O port with alternate functions and pin interrupts.
// Assumes: AHB-Lite slave, single word transfers, always OKAY, zero wait states.
// Notes: Edge/level sensitivity selection is outside this block; any change on an interrupt pin counts.
//
// Function
// - An enabled peripheral output forces the pin to output, overriding direction and option.
// - While a peripheral drives the pin, the data address still reads the pin.
// - A floating input passes its pin level to the peripheral input.
// - Input mode with alternate output enabled reads back the synchronised pin level, not the latch.
// - Output mode with alternate input enabled feeds the data latch to the peripheral.
// - Pull-up only in pull-up input; high driver only in push-pull output.
// - True open-drain pins never pull up nor drive high.
// - Direction/option 00 float in, 01 pull-up irq in, 10 open drain, 11 push-pull.
// - A pin event requests the external interrupt only in interrupt mode with global mask clear; irq follows the pin mask and ignores the global mask.
// - Wait and halt keep pin state; a qualified pin interrupt wakes the device.
// - Data read gives latch for outputs, pin level for inputs; writes always store.
// - The pending request clears when the CPU fetches its vector.
module iop_port
   import iop_pkg::*;
#(
   parameter int W = 8,
   parameter logic [W-1:0] TRUE_OD = '0
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [W-1:0] pad_in,
   output logic [W-1:0] pad_out,
   output logic [W-1:0] pad_oe,
   output logic [W-1:0] pad_pullup_en,
   input wire logic [W-1:0] alt_out_en,
   input wire logic [W-1:0] alt_out,
   input wire logic [W-1:0] alt_in_en,
   output logic [W-1:0] alt_in,
   input wire logic cpu_global_mask,
   input wire logic low_power,
   input wire logic vector_fetch,
   output logic ext_irq_req,
   output logic wake_up,
   output logic irq
);
   // The data, status and mask registers are one byte wide, so wider ports cannot be served.
   if (W < 1 || W > 8) begin : g_bad_width
      $error("iop_port: W must be 1 to 8");
   end

   // ==========================================================
   // Registers.
   logic [W-1:0] data_q;
   logic [W-1:0] dir_q;
   logic [W-1:0] opt_q;
   logic [W-1:0] stat_q;
   logic [W-1:0] mask_q;
   logic [W-1:0] prev_q;
   logic pend_q;
   logic ext_irq_req_q;
   logic wake_q;
   logic irq_q;
   logic [W-1:0] pad_out_q;
   logic [W-1:0] pad_oe_q;
   logic [W-1:0] pull_q;
   logic [W-1:0] alt_in_q;
   logic [31:0] hrdata_q;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic rd_valid;
   logic [7:0] rd_addr;

   // ==========================================================
   // Pad synchroniser.
   iop_sync_if #(.W(W)) sif ();
   assign sif.raw = pad_in;
   iop_sync #(.W(W)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .s(sif)
   );
   wire [W-1:0] pin_lvl = sif.sync;

   // ==========================================================
   // Effective mode per pin.
   wire [W-1:0] out_mode = dir_q | alt_out_en;
   wire [W-1:0] drive_val = (alt_out_en & alt_out) | (~alt_out_en & data_q);
   wire [W-1:0] push_pull = out_mode & (alt_out_en | opt_q) & ~TRUE_OD;
   wire [W-1:0] pullup_mode = ~out_mode & opt_q & ~TRUE_OD;
   wire [W-1:0] irq_mode = ~dir_q & opt_q & ~alt_out_en;
   wire [W-1:0] oe_next = out_mode & (push_pull | ~drive_val);
   // Input pins read the pad; a pin driven by a peripheral also reads the pad.
   wire [W-1:0] data_view = (dir_q & ~alt_out_en & data_q)
                            | ((~dir_q | alt_out_en) & pin_lvl);
   // Peripheral input sees the latch in output mode with alternate input enabled, else the pad.
   wire [W-1:0] alt_in_next = (dir_q & alt_in_en & data_q)
                              | (~(dir_q & alt_in_en) & pin_lvl);

   // ==========================================================
   // Pin events and interrupt pending.
   wire [W-1:0] pin_evt = irq_mode & (pin_lvl ^ prev_q);
   wire any_evt = |pin_evt;
   wire [W-1:0] wr_ones = hwdata[W-1:0];

   // ==========================================================
   // Bus decode.
   wire addr_ok = hsel & hready & (htrans == IOP_HTRANS_NONSEQ || htrans == IOP_HTRANS_SEQ);
   wire wr_data = wr_pend_q && (wr_addr_q == IOP_OFF_DATA);
   wire wr_dir = wr_pend_q && (wr_addr_q == IOP_OFF_DIR);
   wire wr_opt = wr_pend_q && (wr_addr_q == IOP_OFF_OPT);
   wire wr_stat = wr_pend_q && (wr_addr_q == IOP_OFF_IRQ_STAT);
   wire wr_mask = wr_pend_q && (wr_addr_q == IOP_OFF_IRQ_MASK);
   wire wr_cfg = wr_pend_q && (wr_addr_q == IOP_OFF_CFG);
   logic cfg_gmask_q;
   assign rd_valid = addr_ok & ~hwrite;
   assign rd_addr = haddr[7:0];
   wire gmask_eff = cpu_global_mask | cfg_gmask_q;
   wire req_fire = any_evt & ~gmask_eff;

   // Read multiplexer; unmapped addresses read zero.
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (rd_addr)
         IOP_OFF_DATA: rd_mux[W-1:0] = data_view;
         IOP_OFF_DIR: rd_mux[W-1:0] = dir_q;
         IOP_OFF_OPT: rd_mux[W-1:0] = opt_q;
         IOP_OFF_IRQ_STAT: rd_mux[W-1:0] = stat_q;
         IOP_OFF_IRQ_MASK: rd_mux[W-1:0] = mask_q;
         IOP_OFF_CFG: begin
            rd_mux[IOP_CFG_GMASK_BIT] = cfg_gmask_q;
            rd_mux[IOP_CFG_TRUE_OD_LSB +: W] = TRUE_OD;
         end
         IOP_OFF_PEND: rd_mux[0] = pend_q;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // ==========================================================
   // Bus phase tracking.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= IOP_RST_BYTE;
         hrdata_q <= 32'h0000_0000;
      end else begin
         wr_pend_q <= addr_ok & hwrite;
         wr_addr_q <= haddr[7:0];
         if (rd_valid) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   // ==========================================================
   // Port latches; writes always land even in input mode.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_q <= '0;
         dir_q <= '0;
         opt_q <= '0;
         mask_q <= '0;
         cfg_gmask_q <= 1'b0;
      end else begin
         if (wr_data) data_q <= hwdata[W-1:0];
         if (wr_dir) dir_q <= hwdata[W-1:0];
         if (wr_opt) opt_q <= hwdata[W-1:0];
         if (wr_mask) mask_q <= hwdata[W-1:0];
         if (wr_cfg) cfg_gmask_q <= hwdata[IOP_CFG_GMASK_BIT];
      end
   end

   // ==========================================================
   // Interrupt state. Events win over clears so none is lost.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_q <= '0;
         stat_q <= '0;
         pend_q <= 1'b0;
         irq_q <= 1'b0;
         ext_irq_req_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         prev_q <= pin_lvl;
         stat_q <= (stat_q & ~(wr_stat ? wr_ones : '0)) | pin_evt;
         if (req_fire) begin
            pend_q <= 1'b1;
         end else if (vector_fetch) begin
            pend_q <= 1'b0;
         end
         ext_irq_req_q <= (pend_q & ~(vector_fetch & ~req_fire)) | req_fire;
         wake_q <= low_power & (req_fire | pend_q);
         irq_q <= |(((stat_q & ~(wr_stat ? wr_ones : '0)) | pin_evt) & mask_q);
      end
   end

   // ==========================================================
   // Pad drivers. Low-power input is only used for wake; pins keep their state.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pad_out_q <= '0;
         pad_oe_q <= '0;
         pull_q <= '0;
         alt_in_q <= '0;
      end else begin
         pad_out_q <= drive_val & ~TRUE_OD;
         pad_oe_q <= oe_next;
         pull_q <= pullup_mode;
         alt_in_q <= alt_in_next;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign pad_out = pad_out_q;
   assign pad_oe = pad_oe_q;
   assign pad_pullup_en = pull_q;
   assign alt_in = alt_in_q;
   assign ext_irq_req = ext_irq_req_q;
   assign wake_up = wake_q;
   assign irq = irq_q;
endmodule

// File: tb/iop_port_asserts.sv
`timescale 1ns/1ps
// Purpose: Port-level assertions for the I/O port block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound to every instance of the port module.
module iop_port_asserts #(
   parameter int W = 8,
   parameter logic [W-1:0] TRUE_OD = '0
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [W-1:0] pad_out,
   input wire logic [W-1:0] pad_oe,
   input wire logic [W-1:0] pad_pullup_en,
   input wire logic [W-1:0] alt_out_en,
   input wire logic [W-1:0] alt_out,
   input wire logic cpu_global_mask,
   input wire logic low_power,
   input wire logic vector_fetch,
   input wire logic ext_irq_req,
   input wire logic wake_up
);
   // ==========
   // Alternate checks wait two cycles, since the pad outputs are registered.
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_od_no_high: assert property ((pad_out & TRUE_OD) == '0)
      else $error("open-drain pin driven high");
   chk_od_no_pull: assert property ((pad_pullup_en & TRUE_OD) == '0)
      else $error("open-drain pin pulled up");
   chk_pull_not_out: assert property ((pad_pullup_en & pad_oe) == '0)
      else $error("pull-up on a driven pin");
   chk_alt_forces_oe: assert property ((~TRUE_OD & alt_out_en & $past(alt_out_en) & $past(alt_out_en, 2) & ~pad_oe) == '0)
      else $error("alternate output not driving");
   chk_alt_no_pull: assert property (($past(alt_out_en) & $past(alt_out_en, 2) & pad_pullup_en) == '0)
      else $error("pull-up under alternate output");
   chk_mask_blocks: assert property (cpu_global_mask [*5] |-> !$rose(ext_irq_req))
      else $error("request while globally masked");
   chk_fetch_clears: assert property (vector_fetch && cpu_global_mask |-> ##1 !ext_irq_req)
      else $error("request kept after vector fetch");
   chk_wake_lp: assert property (!$past(low_power) |-> !wake_up)
      else $error("wake outside low power");
   chk_lp_hold: assert property (low_power && $past(low_power) && !$past(hsel, 2) && !$past(hsel, 3)
      && ($past(alt_out_en) == $past(alt_out_en, 2)) && ($past(alt_out) == $past(alt_out, 2))
      |-> $stable(pad_oe))
      else $error("pin state moved in low power");
endmodule
bind iop_port iop_port_asserts #(.W(W), .TRUE_OD(TRUE_OD)) chk_u (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en), .alt_out_en(alt_out_en),
   .alt_out(alt_out),
   .cpu_global_mask(cpu_global_mask), .low_power(low_power), .vector_fetch(vector_fetch),
   .ext_irq_req(ext_irq_req), .wake_up(wake_up));

// File: tb/iop_pad_model.sv
`timescale 1ns/1ps
// Purpose: Pad model that resolves the wire level of each pin.
// Assumes: An external driver overrides the weak pull-up.
// Notes: An undriven pin without pull-up shows the inverse of the current external level.
module iop_pad_model (
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] pad_pullup_en,
   input wire logic [7:0] ext_drv,
   input wire logic [7:0] ext_level,
   output logic [7:0] pad_level
);
   // ==========
   // Driven pad wins, then the external source, then the pull-up.
   assign pad_level = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_level)
      | (~pad_oe & ~ext_drv & (pad_pullup_en | ~ext_level));
endmodule

// File: tb/iop_port_tb.sv
`timescale 1ns/1ps
// Purpose: Self-checking bench for the I/O port block.
// Assumes: Zero wait state slave; pins loop back through the pad model.
// Notes: Pin 7 is a true open-drain pin.
module iop_port_tb;
   import iop_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [7:0] ext = 0, drv = 8'hFF, pad_in, pout, poe, pu, aoe = 0, ao = 0, aie = 0, ain;
   logic gmask = 1, lowp = 0, vfetch = 0, eirq, wake, irq;
   int error_cnt = 0, checks_done = 0;
   // ==========
   // The single slave's ready is the bus ready.
   assign hready = hreadyout;
   always #10 hclk = ~hclk;
   iop_port #(.W(8), .TRUE_OD(8'h80)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in), .pad_out(pout), .pad_oe(poe), .pad_pullup_en(pu),
      .alt_out_en(aoe), .alt_out(ao), .alt_in_en(aie), .alt_in(ain), .cpu_global_mask(gmask), .low_power(lowp),
      .vector_fetch(vfetch), .ext_irq_req(eirq), .wake_up(wake), .irq(irq));
   iop_pad_model pad_u (.pad_out(pout), .pad_oe(poe), .pad_pullup_en(pu), .ext_drv(drv), .ext_level(ext),
      .pad_level(pad_in));
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   // Bounded wait for ready; a hang ends the run.
   task automatic hwait();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 100);
      if (n >= 100) begin
         error_cnt++;
         finish_test();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1;
      htrans <= IOP_HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      hwait();
      htrans <= 2'h0;
      hsel <= 0;
      hwdata <= d;
      hwait();
      rd = hrdata;
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(0, a, 0);
      cmp(n, e, rd);
   endtask
   // Pad paths take three edges; four plus a step leaves them settled.
   task automatic sett();
      repeat (4) @(posedge hclk);
      #1;
   endtask
   task automatic t_reset();
      rdc("dir", IOP_OFF_DIR, 0);
      rdc("opt", IOP_OFF_OPT, 0);
      rdc("unmapped", 8'h1C, 0);
      cmp("oe", 0, poe);
   endtask
   task automatic t_modes();
      logic [7:0] eoe[4] = '{8'h00, 8'h00, 8'hF0, 8'hFF};
      logic [7:0] epu[4] = '{8'h00, 8'h7F, 8'h00, 8'h00};
      logic [7:0] erd[4] = '{8'h00, 8'h00, 8'h0F, 8'h0F};
      bus(1, IOP_OFF_DATA, 8'h0F);
      for (int m = 0; m < 4; m++) begin
         bus(1, IOP_OFF_DIR, {8{m[1]}});
         bus(1, IOP_OFF_OPT, {8{m[0]}});
         sett();
         cmp("oe", eoe[m], poe);
         cmp("pullup", epu[m], pu);
         cmp("high", (m == 3) ? 8'h0F : 8'h00, pout & poe);
         rdc("data", IOP_OFF_DATA, erd[m]);
      end
   endtask
   task automatic t_alt();
      bus(1, IOP_OFF_OPT, 0);
      bus(1, IOP_OFF_DIR, 0);
      @(posedge hclk);
      ext <= 8'h99;
      aie <= 8'hFF;
      aoe <= 8'h01;
      sett();
      cmp("oe", 8'h01, poe);
      cmp("alt in", 8'h98, ain & 8'hFE);
      rdc("data", IOP_OFF_DATA, 8'h98);
      @(posedge hclk);
      aoe <= 0;
      ext <= 0;
      bus(1, IOP_OFF_DATA, 8'hC2);
      bus(1, IOP_OFF_DIR, 8'hFF);
      bus(1, IOP_OFF_OPT, 8'hFF);
      sett();
      cmp("alt in", 8'hC2, ain);
   endtask
   task automatic t_irq();
      bus(1, IOP_OFF_OPT, 8'h01);
      bus(1, IOP_OFF_DIR, 0);
      bus(1, IOP_OFF_IRQ_STAT, 8'hFF);
      bus(1, IOP_OFF_IRQ_MASK, 8'h01);
      gmask <= 0;
      ext <= 8'h01;
      sett();
      sett();
      cmp("req", 1, eirq);
      cmp("irq", 1, irq);
      rdc("pend", IOP_OFF_PEND, 1);
      gmask <= 1;
      bus(1, IOP_OFF_IRQ_STAT, 8'h01);
      @(posedge hclk);
      vfetch <= 1;
      @(posedge hclk);
      vfetch <= 0;
      ext <= 0;
      sett();
      sett();
      cmp("req", 0, eirq);
      // The falling pin is a fresh event, so the unmasked status raises irq again.
      cmp("irq", 1, irq);
      bus(1, IOP_OFF_IRQ_STAT, 8'h01);
      sett();
      cmp("irq", 0, irq);
      bus(1, IOP_OFF_IRQ_MASK, 0);
      gmask <= 0;
      lowp <= 1;
      sett();
      ext <= 8'h01;
      sett();
      cmp("wake", 1, wake);
      cmp("irq", 0, irq);
      cmp("oe", 0, poe);
      lowp <= 0;
   endtask
   // Reset for five cycles, then the scenarios in turn.
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1;
      t_reset();
      t_modes();
      t_alt();
      t_irq();
      finish_test();
   end
endmodule
